// ### design/cfbsr_regs.sv
/*
  cfbsr_regs: condition flags, return link, loop count, time counter read side and
  machine state register of the core, with the saved copy of machine state.
  Assumes the execution pipeline issues at most one flag operation, one branch and one
  special register move per cycle, all synchronous to MCLK.
*/
`timescale 1ns/10ps

// Behaviour
// - flag register is eight 4-bit fields, each addressable on its own
// - mask move overwrites only the masked fields from the general register
// - field copy moves all four bits of one field into another
// - one field loads from a float status field or the fixed-point register
// - flag logic combines two chosen flag bits into a third chosen bit
// - integer record sets field 0 from signed test against zero, bit 3 summary overflow
// - field 0: negative bit 0, positive bit 1, zero bit 2, exactly one set
// - undefined integer result leaves first three field 0 bits undefined
// - float record copies float status bits 0 to 3 into field 1
// - compare writes only its target: less, greater, equal; signed or unsigned
// - compare bit 3: summary overflow for integer, unordered for float
// - linking branch writes the next address into return link, taken or not
// - loop count decrements on request, wraps zero to all ones, gives target
// - time counter is 64 bits, upper half bits 0:31, lower half 32:63
// - time counter readable at any privilege through read-only numbers 268, 269
// - one read returns only one 32-bit half of the time counter
// - exception saves machine state then loads exception machine state
// - exception copies machine state bit 15 into the byte-order bit
// - machine state bit 16 clear defers external interrupts
// - machine state bit 17 set permits only user-level instructions
// - machine state bit 18 clear blocks floating-point instruction dispatch
// - reset clears machine state except bit 19 kept and bit 25 from config
module cfbsr_regs
  import cfbsr_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RESET_CONFIG_VECTOR,
  input wire cfbsr_fop_type FLAG_OP,
  input wire logic [2:0] FLAG_DST_FIELD,
  input wire logic [2:0] FLAG_SRC_FIELD,
  input wire logic [7:0] FIELD_MASK,
  input wire logic [31:0] GEN_REG_DATA,
  input wire logic [31:0] FLOAT_STATUS,
  input wire logic [31:0] FIXED_EXC_REG,
  input wire logic [4:0] BIT_A,
  input wire logic [4:0] BIT_B,
  input wire logic [4:0] BIT_D,
  input wire logic [3:0] LOGIC_FN,
  input wire logic [31:0] RESULT_VALUE,
  input wire logic RESULT_UNDEFINED,
  input wire logic [31:0] CMP_A,
  input wire logic [31:0] CMP_B,
  input wire logic CMP_UNSIGNED,
  input wire logic [3:0] FLOAT_CMP_REL,
  input wire logic BR_VALID,
  input wire logic BR_LINK,
  input wire logic BR_DEC_COUNT,
  input wire logic [31:0] BR_NEXT_ADDR,
  input wire logic SPR_WR,
  input wire logic SPR_RD,
  input wire logic [9:0] SPR_NUM,
  input wire logic [31:0] SPR_WDATA,
  input wire logic MS_WR,
  input wire logic [31:0] MS_WDATA,
  input wire logic EXC_TAKE,
  input wire logic EXT_IRQ_REQ,
  input wire logic SUPER_INSTR,
  input wire logic FP_INSTR,
  output logic [31:0] CONDITION_FLAGS,
  output logic [31:0] RETURN_LINK,
  output logic [31:0] LOOP_COUNT,
  output logic [31:0] MACHINE_STATE,
  output logic [31:0] SAVED_STATE,
  output logic [31:0] SPR_RDATA,
  output logic SPR_RD_VALID,
  output logic EXT_IRQ_TAKE,
  output logic PRIV_FAULT,
  output logic FP_BLOCKED
);

  // low vector index of flag field f; field 0 sits in the top nibble
  function automatic logic [4:0] field_lsb(input logic [2:0] f);
    field_lsb = 5'h1c - {f, 2'b00};
  endfunction

  // vector index of a flag bit numbered from the most significant end
  function automatic logic [4:0] bit_idx(input logic [4:0] n);
    bit_idx = 5'h1f - n;
  endfunction

  logic [31:0] flags_r;
  logic [31:0] flags_nxt;
  logic [31:0] link_r;
  logic [31:0] link_nxt;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic [63:0] time_r;
  logic [63:0] time_nxt;
  logic [7:0] prescale_r;
  logic [7:0] prescale_nxt;
  logic [31:0] ms_r;
  logic [31:0] ms_nxt;
  logic [31:0] ms_reset_val;
  logic [31:0] saved_r;
  logic [31:0] saved_nxt;
  logic irq_take_r;
  logic irq_take_nxt;
  logic fault_r;
  logic fault_nxt;
  logic fp_block_r;
  logic fp_block_nxt;
  logic [3:0] int_cmp;
  logic summary_ovf;
  logic user_mode;

  assign summary_ovf = FIXED_EXC_REG[FIXED_SO_IDX];
  assign user_mode = ms_r[MSI_USER_MODE_BIT];

  // integer compare nibble; unsigned and signed ordering share one result path
  always_comb begin
    int_cmp = 4'h0;
    if (CMP_UNSIGNED) begin
      int_cmp[3] = CMP_A < CMP_B;
      int_cmp[2] = CMP_A > CMP_B;
    end else begin
      int_cmp[3] = $signed(CMP_A) < $signed(CMP_B);
      int_cmp[2] = $signed(CMP_A) > $signed(CMP_B);
    end
    int_cmp[1] = CMP_A == CMP_B;
    int_cmp[0] = summary_ovf;
  end

  // flag register: one operation per cycle, each touching only its own field or bit
  always_comb begin
    flags_nxt = flags_r;
    case (FLAG_OP)
      FOP_MOVE_MASK: begin
        // mask bit 7 selects field 0, mask bit 0 selects field 7
        for (int i = 0; i < 8; i++) begin
          if (FIELD_MASK[7 - i]) begin
            flags_nxt[field_lsb(3'(i)) +: 4] = GEN_REG_DATA[field_lsb(3'(i)) +: 4];
          end
        end
      end
      FOP_FIELD_COPY: begin
        flags_nxt[field_lsb(FLAG_DST_FIELD) +: 4] = flags_r[field_lsb(FLAG_SRC_FIELD) +: 4];
      end
      FOP_FROM_FLOAT: begin
        flags_nxt[field_lsb(FLAG_DST_FIELD) +: 4] = FLOAT_STATUS[field_lsb(FLAG_SRC_FIELD) +: 4];
      end
      FOP_FROM_FIXED: begin
        flags_nxt[field_lsb(FLAG_DST_FIELD) +: 4] = FIXED_EXC_REG[31:28];
      end
      FOP_LOGIC: begin
        // truth table indexed by {bit a, bit b}, so any two-input function is possible
        flags_nxt[bit_idx(BIT_D)] = LOGIC_FN[{flags_r[bit_idx(BIT_A)], flags_r[bit_idx(BIT_B)]}];
      end
      FOP_INT_RECORD: begin
        // an undefined result keeps the old three bits rather than inventing a sign
        if (!RESULT_UNDEFINED) begin
          flags_nxt[field_lsb(FIELD_INT_RECORD) + 5'h3] = RESULT_VALUE[31];
          flags_nxt[field_lsb(FIELD_INT_RECORD) + 5'h2] = !RESULT_VALUE[31] && (|RESULT_VALUE);
          flags_nxt[field_lsb(FIELD_INT_RECORD) + 5'h1] = ~(|RESULT_VALUE);
        end
        flags_nxt[field_lsb(FIELD_INT_RECORD)] = summary_ovf;
      end
      FOP_FLOAT_RECORD: begin
        flags_nxt[field_lsb(FIELD_FLOAT_RECORD) +: 4] = FLOAT_STATUS[31:28];
      end
      FOP_INT_CMP: begin
        flags_nxt[field_lsb(FLAG_DST_FIELD) +: 4] = int_cmp;
      end
      FOP_FLOAT_CMP: begin
        // float unit supplies {less, greater, equal, unordered}
        flags_nxt[field_lsb(FLAG_DST_FIELD) +: 4] = FLOAT_CMP_REL;
      end
      default: begin
        flags_nxt = flags_r;
      end
    endcase
  end

  // flags clear at reset so the first record or compare starts from a known image
  always_ff @(posedge MCLK) begin
    if (RST) begin
      flags_r <= FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // return link and loop count; a branch beats a move issued in the same cycle
  always_comb begin
    link_nxt = link_r;
    count_nxt = count_r;
    if (SPR_WR && (SPR_NUM == SPR_RETURN_LINK)) begin
      link_nxt = SPR_WDATA;
    end
    if (SPR_WR && (SPR_NUM == SPR_LOOP_COUNT)) begin
      count_nxt = SPR_WDATA;
    end
    if (BR_VALID && BR_LINK) begin
      link_nxt = BR_NEXT_ADDR;
    end
    if (BR_VALID && BR_DEC_COUNT) begin
      count_nxt = count_r - 32'h1;
    end
  end

  // link and count registers; the subtraction wraps zero to all ones by itself,
  // so a loop count of zero runs the full 32-bit range rather than stopping
  always_ff @(posedge MCLK) begin
    if (RST) begin
      link_r <= LINK_RESET;
      count_r <= COUNT_RESET;
    end else begin
      link_r <= link_nxt;
      count_r <= count_nxt;
    end
  end

  // time counter: free-running tick prescaler, carry from low into high half
  always_comb begin
    prescale_nxt = prescale_r + 8'h1;
    time_nxt = time_r;
    if (prescale_r == TICK_LAST) begin
      prescale_nxt = 8'h0;
      time_nxt = time_r + 64'h1;
    end
  end

  // counter and prescaler; no write path, so software can only ever read it
  always_ff @(posedge MCLK) begin
    if (RST) begin
      time_r <= TIME_RESET;
      prescale_r <= 8'h0;
    end else begin
      time_r <= time_nxt;
      prescale_r <= prescale_nxt;
    end
  end

  // special register reads; counter numbers are read-only and need no privilege
  always_comb begin
    rdata_nxt = 32'h0;
    rd_valid_nxt = SPR_RD;
    if (SPR_RD) begin
      if (SPR_NUM == SPR_RETURN_LINK) begin
        rdata_nxt = link_r;
      end else if (SPR_NUM == SPR_LOOP_COUNT) begin
        rdata_nxt = count_r;
      end else if (SPR_NUM == SPR_COUNTER_LOW) begin
        rdata_nxt = time_r[31:0];
      end else if (SPR_NUM == SPR_COUNTER_HIGH) begin
        rdata_nxt = time_r[63:32];
      end else begin
        rdata_nxt = 32'h0;
      end
    end
  end

  // read data is a one-cycle answer; it drops to zero so a stale word never looks fresh
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_r <= 32'h0;
      rd_valid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // reset image: machine check allow survives, vector base comes from the config pin
  assign ms_reset_val = (ms_r & MS_RESET_KEEP) | (RESET_CONFIG_VECTOR ? MS_VECTOR_BASE_MASK : 32'h0);

  // machine state: exception entry has priority over a software write
  always_comb begin
    ms_nxt = ms_r;
    saved_nxt = saved_r;
    fault_nxt = 1'b0;
    if (EXC_TAKE) begin
      saved_nxt = ms_r;
      ms_nxt = ms_r & MS_EXC_KEEP;
      ms_nxt[MSI_BYTE_ORDER_BIT] = ms_r[MSI_HANDLER_BYTE_ORDER];
    end else if (MS_WR) begin
      if (user_mode) begin
        fault_nxt = 1'b1;
      end else begin
        ms_nxt = MS_WDATA;
      end
    end
    if (SUPER_INSTR && user_mode) begin
      fault_nxt = 1'b1;
    end
  end

  // gating outputs derived from the current machine state
  always_comb begin
    irq_take_nxt = EXT_IRQ_REQ && ms_r[MSI_EXTERNAL_IRQ_ALLOW];
    fp_block_nxt = FP_INSTR && !ms_r[MSI_FLOAT_AVAILABLE];
  end

  // gate flops; they follow the state one cycle late, so a write lands before it gates
  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_take_r <= 1'b0;
      fp_block_r <= 1'b0;
    end else begin
      irq_take_r <= irq_take_nxt;
      fp_block_r <= fp_block_nxt;
    end
  end

  // synchronous reset, so the reset image may read the old state and the config pin
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ms_r <= ms_reset_val;
      saved_r <= 32'h0;
      fault_r <= 1'b0;
    end else begin
      ms_r <= ms_nxt;
      saved_r <= saved_nxt;
      fault_r <= fault_nxt;
    end
  end

  // every output is a flip-flop
  assign CONDITION_FLAGS = flags_r;
  assign RETURN_LINK = link_r;
  assign LOOP_COUNT = count_r;
  assign MACHINE_STATE = ms_r;
  assign SAVED_STATE = saved_r;
  assign SPR_RDATA = rdata_r;
  assign SPR_RD_VALID = rd_valid_r;
  assign EXT_IRQ_TAKE = irq_take_r;
  assign PRIV_FAULT = fault_r;
  assign FP_BLOCKED = fp_block_r;

endmodule

// ### pkg/cfbsr_pkg.sv
/*
  cfbsr_pkg: constants and types for the flag, branch and machine state register block.
  Assumes bit numbering with bit 0 as the most significant bit of each register;
  vector index = 31 - bit number for 32-bit registers.
*/
package cfbsr_pkg;

  // clock and time counter tick rate
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 100;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

  // special register numbers
  localparam logic [9:0] SPR_RETURN_LINK = 10'h008;
  localparam logic [9:0] SPR_LOOP_COUNT = 10'h009;
  localparam logic [9:0] SPR_COUNTER_LOW = 10'h10c;
  localparam logic [9:0] SPR_COUNTER_HIGH = 10'h10d;

  // machine state bit numbers and their vector indices
  localparam int MS_HANDLER_BYTE_ORDER = 15;
  localparam int MS_EXTERNAL_IRQ_ALLOW = 16;
  localparam int MS_USER_MODE_BIT = 17;
  localparam int MS_FLOAT_AVAILABLE = 18;
  localparam int MS_MACHINE_CHECK_ALLOW = 19;
  localparam int MS_VECTOR_BASE_SELECT = 25;
  localparam int MS_BYTE_ORDER_BIT = 31;
  localparam int MSI_HANDLER_BYTE_ORDER = 31 - MS_HANDLER_BYTE_ORDER;
  localparam int MSI_EXTERNAL_IRQ_ALLOW = 31 - MS_EXTERNAL_IRQ_ALLOW;
  localparam int MSI_USER_MODE_BIT = 31 - MS_USER_MODE_BIT;
  localparam int MSI_FLOAT_AVAILABLE = 31 - MS_FLOAT_AVAILABLE;
  localparam int MSI_VECTOR_BASE_SELECT = 31 - MS_VECTOR_BASE_SELECT;
  localparam int MSI_BYTE_ORDER_BIT = 31 - MS_BYTE_ORDER_BIT;

  // bits kept across reset and across exception entry
  localparam logic [31:0] MS_RESET_KEEP = 32'h00001000;
  localparam logic [31:0] MS_EXC_KEEP = 32'h00011040;
  localparam logic [31:0] MS_VECTOR_BASE_MASK = 32'h00000040;

  // reset values of the remaining registers
  localparam logic [31:0] FLAGS_RESET = 32'h00000000;
  localparam logic [31:0] LINK_RESET = 32'h00000000;
  localparam logic [31:0] COUNT_RESET = 32'h00000000;
  localparam logic [63:0] TIME_RESET = 64'h0000000000000000;

  // implicit record fields and summary-overflow position of the fixed-point register
  localparam logic [2:0] FIELD_INT_RECORD = 3'h0;
  localparam logic [2:0] FIELD_FLOAT_RECORD = 3'h1;
  localparam int FIXED_SO_IDX = 31;

  // flag register operations, one per cycle
  typedef enum logic [3:0] {
    FOP_NONE, FOP_MOVE_MASK, FOP_FIELD_COPY, FOP_FROM_FLOAT, FOP_FROM_FIXED,
    FOP_LOGIC, FOP_INT_RECORD, FOP_FLOAT_RECORD, FOP_INT_CMP, FOP_FLOAT_CMP
  } cfbsr_fop_type;

endpackage

// ### testbench/cfbsr_chk.sv
/*
  cfbsr_chk: port assertions for cfbsr_regs.
  Assumes the bind at the foot of this file; sees top-level ports only.
*/
`timescale 1ns/10ps
module cfbsr_chk (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RESET_CONFIG_VECTOR,
  input wire logic BR_VALID,
  input wire logic BR_LINK,
  input wire logic BR_DEC_COUNT,
  input wire logic [31:0] BR_NEXT_ADDR,
  input wire logic SPR_RD,
  input wire logic EXC_TAKE,
  input wire logic EXT_IRQ_REQ,
  input wire logic FP_INSTR,
  input wire logic [31:0] RETURN_LINK,
  input wire logic [31:0] LOOP_COUNT,
  input wire logic [31:0] MACHINE_STATE,
  input wire logic [31:0] SAVED_STATE,
  input wire logic SPR_RD_VALID,
  input wire logic EXT_IRQ_TAKE,
  input wire logic FP_BLOCKED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // branch, move and exception effects, each tied to its cause one cycle back
  a_link_write: assert property (BR_VALID && BR_LINK |=> RETURN_LINK == $past(BR_NEXT_ADDR))
    else $error("link not written");
  a_count_step: assert property (BR_VALID && BR_DEC_COUNT |=> LOOP_COUNT == $past(LOOP_COUNT) - 32'h1)
    else $error("count not decremented");
  a_read_pulse: assert property (SPR_RD |=> SPR_RD_VALID)
    else $error("read not answered");
  a_exc_save: assert property (EXC_TAKE |=> SAVED_STATE == $past(MACHINE_STATE))
    else $error("state not saved");
  a_handler_order: assert property (EXC_TAKE |=> MACHINE_STATE[0] == $past(MACHINE_STATE[16]))
    else $error("byte order not copied");
  // gates are registered, so reset at the previous edge forces them low
  a_irq_gate: assert property (EXT_IRQ_TAKE == (!$past(RST) && $past(EXT_IRQ_REQ && MACHINE_STATE[15])))
    else $error("interrupt gate wrong");
  a_float_gate: assert property (FP_BLOCKED == (!$past(RST) && $past(FP_INSTR && !MACHINE_STATE[13])))
    else $error("float gate wrong");
  a_reset_state: assert property ($past(RST) |-> {MACHINE_STATE[31:13], MACHINE_STATE[11:0]} ==
    {19'h0, 5'h0, $past(RESET_CONFIG_VECTOR), 6'h0}) else $error("reset state wrong");
endmodule

bind cfbsr_regs cfbsr_chk u_chk (.MCLK, .RST, .RESET_CONFIG_VECTOR, .BR_VALID, .BR_LINK, .BR_DEC_COUNT,
  .BR_NEXT_ADDR, .SPR_RD, .EXC_TAKE, .EXT_IRQ_REQ, .FP_INSTR, .RETURN_LINK, .LOOP_COUNT, .MACHINE_STATE,
  .SAVED_STATE, .SPR_RD_VALID, .EXT_IRQ_TAKE, .FP_BLOCKED);

// ### testbench/cfbsr_pipe.sv
/*
  cfbsr_pipe: branch issue stage of the execution pipeline.
  Assumes go, lk, dc and ad change just after a rising edge.
*/
`timescale 1ns/10ps
module cfbsr_pipe (
  input wire logic MCLK,
  input wire logic go,
  input wire logic lk,
  input wire logic dc,
  input wire logic [31:0] ad,
  output logic BR_VALID,
  output logic BR_LINK,
  output logic BR_DEC_COUNT,
  output logic [31:0] BR_NEXT_ADDR
);
  // one branch per go cycle; idle address keeps flipping so no stale value looks valid
  always_ff @(posedge MCLK) begin
    BR_VALID <= go;
    BR_LINK <= go & lk;
    BR_DEC_COUNT <= go & dc;
    BR_NEXT_ADDR <= go ? ad : ~BR_NEXT_ADDR;
  end
endmodule

// ### testbench/cpu_flags_branch_state_regs_bench.sv
/*
  Testbench for cfbsr_regs: flag operations, branches, special moves, machine state.
  Assumes a 40 MHz clock and inputs driven 1 ns after each rising edge.
*/
`timescale 1ns/10ps
module cpu_flags_branch_state_regs_bench;
  import cfbsr_pkg::*;
  logic MCLK, RST, RESET_CONFIG_VECTOR, RESULT_UNDEFINED, CMP_UNSIGNED, SPR_WR, SPR_RD, MS_WR, EXC_TAKE;
  logic EXT_IRQ_REQ, SUPER_INSTR, FP_INSTR, SPR_RD_VALID, EXT_IRQ_TAKE, PRIV_FAULT, FP_BLOCKED;
  logic BR_VALID, BR_LINK, BR_DEC_COUNT, go, lk, dc;
  logic [2:0] FLAG_DST_FIELD, FLAG_SRC_FIELD;
  logic [3:0] LOGIC_FN, FLOAT_CMP_REL;
  logic [4:0] BIT_A, BIT_B, BIT_D;
  logic [7:0] FIELD_MASK;
  logic [9:0] SPR_NUM;
  logic [31:0] GEN_REG_DATA, FLOAT_STATUS, FIXED_EXC_REG, RESULT_VALUE, CMP_A, CMP_B, SPR_WDATA, MS_WDATA;
  logic [31:0] BR_NEXT_ADDR, CONDITION_FLAGS, RETURN_LINK, LOOP_COUNT, MACHINE_STATE, SAVED_STATE, SPR_RDATA;
  logic [31:0] ad, ef, t0;
  cfbsr_fop_type FLAG_OP;
  int fail_count, compares;

  cfbsr_regs dut (.*);
  cfbsr_pipe pipe (.MCLK, .go, .lk, .dc, .ad, .BR_VALID, .BR_LINK, .BR_DEC_COUNT, .BR_NEXT_ADDR);

  // free-running core clock
  initial begin
    MCLK = 0;
    forever #12.5 MCLK = ~MCLK;
  end

  task chk(string n, logic [63:0] g, logic [63:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task step;
    @(posedge MCLK) #1;
  endtask

  // one flag operation, then the register is compared with the running model
  task fop(cfbsr_fop_type o);
    step;
    FLAG_OP = o;
    step;
    FLAG_OP = FOP_NONE;
    chk("flags", CONDITION_FLAGS, ef);
  endtask

  // an idle edge leads each move, so back-to-back moves never drop and raise a strobe together
  task sr(logic w, logic [9:0] n, logic [31:0] d);
    step;
    SPR_WR = w;
    SPR_RD = !w;
    SPR_NUM = n;
    SPR_WDATA = d;
    step;
    {SPR_WR, SPR_RD} = 2'h0;
  endtask

  task msw(logic [31:0] d);
    MS_WR = 1;
    MS_WDATA = d;
    step;
    MS_WR = 0;
  endtask

  task conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang is cut short after far more cycles than the sequence needs
  initial begin
    #50000;
    fail_count++;
    conclude;
  end

  initial begin
    {RESULT_UNDEFINED, CMP_UNSIGNED, SPR_WR, SPR_RD, MS_WR, EXC_TAKE, EXT_IRQ_REQ, SUPER_INSTR, FP_INSTR} = '0;
    {go, lk, dc, FLAG_DST_FIELD, FLAG_SRC_FIELD, LOGIC_FN, FLOAT_CMP_REL, BIT_A, BIT_B, BIT_D} = '0;
    {FIELD_MASK, SPR_NUM, GEN_REG_DATA, FLOAT_STATUS, FIXED_EXC_REG, RESULT_VALUE, CMP_A, CMP_B} = '0;
    {SPR_WDATA, MS_WDATA, ad, ef} = '0;
    FLAG_OP = FOP_NONE;
    RESET_CONFIG_VECTOR = 1;
    RST = 1;
    repeat (2) @(posedge MCLK);
    #1 RST = 0;
    chk("reset state", MACHINE_STATE & 32'hffffefff, 32'h40);
    // flag field moves, copies and bit logic
    GEN_REG_DATA = 32'h12345678;
    FIELD_MASK = 8'ha5;
    ef = 32'h10300608;
    fop(FOP_MOVE_MASK);
    FLAG_DST_FIELD = 3;
    ef = 32'h10310608;
    fop(FOP_FIELD_COPY);
    FIXED_EXC_REG = 32'hb0000000;
    FLAG_DST_FIELD = 1;
    ef = 32'h1b310608;
    fop(FOP_FROM_FIXED);
    {FLOAT_STATUS, FLAG_SRC_FIELD, FLAG_DST_FIELD} = {32'h00c00000, 3'h2, 3'h6};
    ef = 32'h1b3106c8;
    fop(FOP_FROM_FLOAT);
    {BIT_A, BIT_B, BIT_D, LOGIC_FN} = {5'h3, 5'h4, 5'hc, 4'h8};
    ef = 32'h1b3906c8;
    fop(FOP_LOGIC);
    // record forms: negative, positive, zero, then an undefined result
    FIXED_EXC_REG = 32'h80000000;
    for (int i = 0; i < 3; i++) begin
      RESULT_VALUE = i == 0 ? 32'h80000000 : 32'(2 - i);
      ef[31:28] = (4'h8 >> i) | 4'h1;
      fop(FOP_INT_RECORD);
    end
    {FIXED_EXC_REG, RESULT_UNDEFINED} = 33'h1;
    ef[31:28] = 4'h2;
    fop(FOP_INT_RECORD);
    FLOAT_STATUS = 32'ha0000000;
    ef[27:24] = 4'ha;
    fop(FOP_FLOAT_RECORD);
    // compares into field 7: signed less, unsigned greater with overflow, equal
    FLAG_DST_FIELD = 7;
    for (int i = 0; i < 3; i++) begin
      CMP_UNSIGNED = i == 1;
      FIXED_EXC_REG = {i == 1, 31'h0};
      {CMP_A, CMP_B} = i == 2 ? {32'h5, 32'h5} : {32'hffffffff, 32'h1};
      ef[3:0] = i == 0 ? 4'h8 : i == 1 ? 4'h5 : 4'h2;
      fop(FOP_INT_CMP);
    end
    FLOAT_CMP_REL = 4'h1;
    ef[3:0] = 4'h1;
    fop(FOP_FLOAT_CMP);
    // linking branch with count wrap, then two back-to-back plain decrements
    {ad, lk, dc, go} = {32'h104, 3'h7};
    step;
    go = 0;
    step;
    chk("link", RETURN_LINK, 32'h104);
    chk("count", LOOP_COUNT, 32'hffffffff);
    {lk, go} = 2'h1;
    repeat (2) step;
    go = 0;
    step;
    chk("count", LOOP_COUNT, 32'hfffffffd);
    chk("link", RETURN_LINK, 32'h104);
    // special register moves, unmapped number included
    sr(1, 10'h8, 32'hcafe0001);
    sr(0, 10'h8, 0);
    chk("link read", SPR_RDATA, 32'hcafe0001);
    sr(1, 10'h9, 32'h5);
    sr(0, 10'h3ff, 0);
    chk("unmapped", {SPR_RD_VALID, SPR_RDATA}, 33'h100000000);
    chk("count", LOOP_COUNT, 32'h5);
    sr(0, 10'h9, 0);
    chk("count read", SPR_RDATA, 32'h5);
    // machine state gates and exception entry
    msw(32'h0001b000);
    {EXT_IRQ_REQ, FP_INSTR} = 2'h3;
    step;
    chk("gates", {EXT_IRQ_TAKE, FP_BLOCKED}, 2'h2);
    EXC_TAKE = 1;
    step;
    EXC_TAKE = 0;
    chk("saved", SAVED_STATE, 32'h0001b000);
    chk("state", MACHINE_STATE, 32'h00011001);
    step;
    chk("gates", {EXT_IRQ_TAKE, FP_BLOCKED}, 2'h1);
    EXT_IRQ_REQ = 0;
    // user mode: supervisor work faults, state write refused, counter still readable
    msw(32'h00004000);
    SUPER_INSTR = 1;
    step;
    SUPER_INSTR = 0;
    chk("fault", PRIV_FAULT, 1);
    msw(32'h0);
    chk("user", {PRIV_FAULT, MACHINE_STATE}, 33'h100004000);
    sr(1, 10'h10c, 32'hffffffff);
    sr(0, 10'h10c, 0);
    t0 = SPR_RDATA;
    // the two reads are taken eight edges apart: exactly two ticks at one per four clocks
    repeat (6) step;
    sr(0, 10'h10c, 0);
    chk("low half", SPR_RDATA, t0 + 32'h2);
    sr(0, 10'h10d, 0);
    chk("high half", {SPR_RD_VALID, SPR_RDATA}, 33'h100000000);
    conclude;
  end
endmodule
